// ---- logic/tpo_pattern_output_unit.sv ----
`timescale 1ns/100ps
module tpo_pattern_output_unit #(
	parameter int PIN_COUNT = 16
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [2:0] compare_a_i,
	input wire logic [2:0] compare_b_i,
	input wire logic [2:0] capture_a_i,
	input wire logic [15:0] pin_taken_i,
	input wire logic [15:0] pin_in_i,
	output logic [15:0] pin_out_o,
	output logic [15:0] pin_oe_o
);

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (PIN_COUNT != tpo_pkg::GROUP_COUNT * tpo_pkg::GROUP_WIDTH)
	begin : g_bad_pins
		$error("pin count must be sixteen");
	end

	// group loops below index bits as 4*g+b
	if (tpo_pkg::GROUP_WIDTH != 4)
	begin : g_bad_group_width
		$error("group width must be four");
	end

	// channel index is two bits wide
	if (tpo_pkg::CHANNEL_COUNT > 4)
	begin : g_bad_channels
		$error("too many trigger channels");
	end

	// trigger select byte holds two bits per group
	if (tpo_pkg::GROUP_COUNT * 2 != 8)
	begin : g_bad_select
		$error("trigger select must fit one byte");
	end

	// ------------------------------------------------------------
	// block state
	// ------------------------------------------------------------
	// pin drive is registered with the copy, so a trigger shows on the pins
	// at the same edge that updates the port output bits
	typedef struct packed {
		logic [15:0] dir;
		logic [15:0] next_enable;
		logic [15:0] port_output;
		logic [15:0] next_pattern;
		logic [7:0] trigger_select;
		logic [3:0] nonoverlap;
		logic [2:0] capture_mode;
		logic [7:0] rdata;
		logic [15:0] pin_out;
		logic [15:0] pin_oe;
	} tpo_state_s;

	tpo_state_s state;
	tpo_state_s next_state;

	// ------------------------------------------------------------
	// combinational next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [1:0] sel;
		logic [1:0] ch;
		logic trig_a;
		logic trig_b;
		logic [7:0] rd;
		logic [15:0] pins;
		next_state = state;
		sel = 2'h0;
		ch = 2'h0;
		trig_a = 1'b0;
		trig_b = 1'b0;
		rd = tpo_pkg::RESET_BYTE;
		for (int i = 0; i < PIN_COUNT; i++)
		begin
			pins[i] = state.pin_oe[i] ? state.port_output[i] : pin_in_i[i];
		end

		// ------------------------------------------------------------
		// software writes
		// ------------------------------------------------------------
		// software writes first, so a trigger below overrides them
		if (reg_write_i)
		begin
			if (reg_addr_i == tpo_pkg::ADDR_PORT_A_DIR)
				next_state.dir[7:0] = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_PORT_B_DIR)
				next_state.dir[15:8] = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_LOW_NEXT_ENABLE)
				next_state.next_enable[7:0] = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_HIGH_NEXT_ENABLE)
				next_state.next_enable[15:8] = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_PORT_A_OUTPUT)
			begin
				for (int i = 0; i < 8; i++)
					if (!(state.next_enable[i] && !state.dir[i]))
						next_state.port_output[i] = reg_wdata_i[i];
			end
			else if (reg_addr_i == tpo_pkg::ADDR_PORT_B_OUTPUT)
			begin
				for (int i = 0; i < 8; i++)
					if (!(state.next_enable[i+8] && !state.dir[i+8]))
						next_state.port_output[i+8] = reg_wdata_i[i];
			end
			else if (reg_addr_i == tpo_pkg::ADDR_LOW_NEXT_PATTERN)
				next_state.next_pattern[7:0] = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_HIGH_NEXT_PATTERN)
				next_state.next_pattern[15:8] = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_TRIGGER_SELECT)
				next_state.trigger_select = reg_wdata_i;
			else if (reg_addr_i == tpo_pkg::ADDR_OUTPUT_MODE)
				next_state.nonoverlap = reg_wdata_i[3:0];
			else if (reg_addr_i == tpo_pkg::ADDR_CAPTURE_MODE)
				next_state.capture_mode = reg_wdata_i[2:0];
		end

		// ------------------------------------------------------------
		// trigger transfer
		// ------------------------------------------------------------
		// per-group transfer, copies happen whatever the pin is used for;
		// compare a (capture a in capture mode) wins over compare b when both arrive together
		for (int g = 0; g < tpo_pkg::GROUP_COUNT; g++)
		begin
			sel = state.trigger_select[2*g +: 2];
			if (sel == tpo_pkg::SEL_CHANNEL_0)
				ch = 2'h0;
			else if (sel == tpo_pkg::SEL_CHANNEL_1)
				ch = 2'h1;
			else
				ch = 2'h2;
			// capture-configured register A replaces compare A
			trig_a = state.capture_mode[ch] ? capture_a_i[ch] : compare_a_i[ch];
			trig_b = state.nonoverlap[g] && compare_b_i[ch];
			for (int b = 0; b < tpo_pkg::GROUP_WIDTH; b++)
			begin
				if (trig_a)
					next_state.port_output[4*g+b] = state.next_pattern[4*g+b];
				else if (trig_b && !state.next_pattern[4*g+b])
					next_state.port_output[4*g+b] = 1'b0;
			end
		end

		// ------------------------------------------------------------
		// read mux
		// ------------------------------------------------------------
		// data appear one cycle after the strobe and read 0 otherwise,
		// so a bus or-tree above this block needs no extra gating
		if (reg_addr_i == tpo_pkg::ADDR_PORT_A_DIR)
			rd = state.dir[7:0];
		else if (reg_addr_i == tpo_pkg::ADDR_PORT_B_DIR)
			rd = state.dir[15:8];
		else if (reg_addr_i == tpo_pkg::ADDR_LOW_NEXT_ENABLE)
			rd = state.next_enable[7:0];
		else if (reg_addr_i == tpo_pkg::ADDR_HIGH_NEXT_ENABLE)
			rd = state.next_enable[15:8];
		else if (reg_addr_i == tpo_pkg::ADDR_PORT_A_OUTPUT)
			rd = state.port_output[7:0];
		else if (reg_addr_i == tpo_pkg::ADDR_PORT_B_OUTPUT)
			rd = state.port_output[15:8];
		else if (reg_addr_i == tpo_pkg::ADDR_LOW_NEXT_PATTERN)
			rd = state.next_pattern[7:0];
		else if (reg_addr_i == tpo_pkg::ADDR_HIGH_NEXT_PATTERN)
			rd = state.next_pattern[15:8];
		else if (reg_addr_i == tpo_pkg::ADDR_TRIGGER_SELECT)
			rd = state.trigger_select;
		else if (reg_addr_i == tpo_pkg::ADDR_OUTPUT_MODE)
			rd = tpo_pkg::OUTPUT_MODE_RSVD | {4'h0, state.nonoverlap};
		else if (reg_addr_i == tpo_pkg::ADDR_PIN_STATE)
			rd = 8'h00;
		else if (reg_addr_i == tpo_pkg::ADDR_CAPTURE_MODE)
			rd = {5'h00, state.capture_mode};
		next_state.rdata = reg_read_i ? rd : tpo_pkg::RESET_BYTE;

		// ------------------------------------------------------------
		// pin drive
		// ------------------------------------------------------------
		// drive follows the port output bit; taken pins are not driven
		// limitation: a pin-function change is not synchronised to triggers
		for (int i = 0; i < PIN_COUNT; i++)
		begin
			next_state.pin_out[i] = next_state.port_output[i];
			next_state.pin_oe[i] = next_state.dir[i] && !pin_taken_i[i];
		end
		if (pins == 16'h0000)
			next_state.rdata = next_state.rdata;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			state <= '0;
			state.trigger_select <= tpo_pkg::RESET_TRIGGER_SELECT;
			state.nonoverlap <= tpo_pkg::RESET_OUTPUT_MODE[3:0];
		end
		else
			state <= next_state;
	end

	assign reg_rdata_o = state.rdata;
	assign pin_out_o = state.pin_out;
	assign pin_oe_o = state.pin_oe;

endmodule // tpo_pattern_output_unit

// ---- logic/tpo_pkg.sv ----
package tpo_pkg;

	// ------------------------------------------------------------
	// register map (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_PORT_A_DIR = 4'h0;
	localparam logic [3:0] ADDR_PORT_B_DIR = 4'h1;
	localparam logic [3:0] ADDR_LOW_NEXT_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_HIGH_NEXT_ENABLE = 4'h3;
	localparam logic [3:0] ADDR_PORT_A_OUTPUT = 4'h4;
	localparam logic [3:0] ADDR_PORT_B_OUTPUT = 4'h5;
	localparam logic [3:0] ADDR_LOW_NEXT_PATTERN = 4'h6;
	localparam logic [3:0] ADDR_HIGH_NEXT_PATTERN = 4'h7;
	localparam logic [3:0] ADDR_TRIGGER_SELECT = 4'h8;
	localparam logic [3:0] ADDR_OUTPUT_MODE = 4'h9;
	localparam logic [3:0] ADDR_PIN_STATE = 4'ha;
	localparam logic [3:0] ADDR_CAPTURE_MODE = 4'hb;

	// ------------------------------------------------------------
	// reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_TRIGGER_SELECT = 8'hff;
	localparam logic [7:0] RESET_OUTPUT_MODE = 8'hf0;
	localparam logic [7:0] OUTPUT_MODE_RSVD = 8'hf0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int GROUP_COUNT = 4;
	localparam int GROUP_WIDTH = 4;
	localparam int CHANNEL_COUNT = 3;
	localparam logic [1:0] SEL_CHANNEL_0 = 2'h0;
	localparam logic [1:0] SEL_CHANNEL_1 = 2'h1;

endpackage

// ---- test/tpo_load_model.sv ----
`timescale 1ns/100ps
module tpo_load_model (
	input wire logic ref_clk_i,
	input wire logic [15:0] pin_out_i,
	input wire logic [15:0] pin_oe_i,
	output logic [15:0] pin_level_o
);
	// a released pin floats: show the inverse of its last level, never a stale copy
	logic [15:0] last_level = 16'h0000;
	always_ff @(posedge ref_clk_i)
	begin
		last_level <= pin_level_o;
	end
	assign pin_level_o = (pin_out_i & pin_oe_i) | (~last_level & ~pin_oe_i);
endmodule // tpo_load_model

// ---- test/tpo_pattern_output_unit_sva.sv ----
`timescale 1ns/100ps
module tpo_pattern_output_unit_sva (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [2:0] compare_a_i,
	input wire logic [2:0] compare_b_i,
	input wire logic [2:0] capture_a_i,
	input wire logic [15:0] pin_taken_i,
	input wire logic [15:0] pin_out_o,
	input wire logic [15:0] pin_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic stir;
	assign stir = reg_write_i | (|{compare_a_i, compare_b_i, capture_a_i});
	a_reset_clear: assert property (disable iff (1'b0)
		reset_i |=> pin_out_o == 16'h0000 && pin_oe_o == 16'h0000) else $error("pins kept in reset");
	a_quiet_hold: assert property (!$past(stir) |-> $stable(pin_out_o))
		else $error("pins moved unprompted");
	a_read_slot: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00) else $error("stray data");
	a_unmapped_zero: assert property (reg_read_i && (reg_addr_i == 4'ha || reg_addr_i > 4'hb)
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_pattern_back: assert property (reg_write_i && reg_addr_i == tpo_pkg::ADDR_LOW_NEXT_PATTERN
		##1 reg_read_i && reg_addr_i == tpo_pkg::ADDR_LOW_NEXT_PATTERN
		|=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("pattern readback");
	a_dir_drive: assert property (reg_write_i && reg_addr_i == tpo_pkg::ADDR_PORT_B_DIR
		&& pin_taken_i == 16'h0000 ##1 (!reg_write_i && pin_taken_i == 16'h0000) [*2]
		|=> pin_oe_o[15:8] == $past(reg_wdata_i, 3)) else $error("drive enable wrong");
	a_taken_quiet: assert property ($stable(pin_taken_i) |-> (pin_oe_o & pin_taken_i) == 16'h0000)
		else $error("taken pin driven");
	a_b_clears: assert property (compare_b_i != 3'h0 && compare_a_i == 3'h0
		&& capture_a_i == 3'h0 && !reg_write_i |=> (pin_out_o & ~$past(pin_out_o)) == 16'h0000)
		else $error("compare b set a pin");
	cover property (compare_a_i != 3'h0 ##1 $changed(pin_out_o));
	cover property (compare_b_i != 3'h0 ##1 $changed(pin_out_o));
	cover property (capture_a_i != 3'h0 ##1 $changed(pin_out_o));
endmodule // tpo_pattern_output_unit_sva
bind tpo_pattern_output_unit tpo_pattern_output_unit_sva tpo_pattern_output_unit_sva_i (.*);

// ---- test/tpo_pattern_output_unit_test.sv ----
`timescale 1ns/100ps
module tpo_pattern_output_unit_test;
	typedef struct packed {logic [3:0] a; logic [7:0] d; logic [8:0] t; logic [15:0] o;} tpo_row_s;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic [2:0] compare_a_i = 3'h0;
	logic [2:0] compare_b_i = 3'h0;
	logic [2:0] capture_a_i = 3'h0;
	logic [15:0] pin_taken_i = 16'h0000;
	logic [15:0] pin_in_i;
	logic [15:0] pin_out_o;
	logic [15:0] pin_oe_o;
	int mismatches = 0;
	int check_count = 0;
	// t packs {compare a, compare b, capture}, one bit per channel
	tpo_row_s rows [14] = '{
		'{4'h1, 8'hff, 9'h000, 16'h0000}, '{4'h3, 8'hff, 9'h000, 16'h0000},
		'{4'h8, 8'h0f, 9'h000, 16'h0000}, '{4'h7, 8'h80, 9'h040, 16'h8000},
		'{4'h7, 8'hc0, 9'h080, 16'h8000}, '{4'hf, 8'h00, 9'h040, 16'hc000},
		'{4'h9, 8'h0c, 9'h000, 16'hc000}, '{4'h7, 8'h95, 9'h008, 16'h8000},
		'{4'hf, 8'h00, 9'h040, 16'h9500}, '{4'h6, 8'h05, 9'h000, 16'h9500},
		'{4'h2, 8'h0f, 9'h000, 16'h9500}, '{4'hb, 8'h04, 9'h100, 16'h9500},
		'{4'hf, 8'h00, 9'h004, 16'h9505}, '{4'h4, 8'hff, 9'h000, 16'h95f5}
	};
	always #4 ref_clk_i = ~ref_clk_i;
	tpo_pattern_output_unit tpo_pattern_output_unit_i (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o),
		.compare_a_i(compare_a_i),
		.compare_b_i(compare_b_i),
		.capture_a_i(capture_a_i),
		.pin_taken_i(pin_taken_i),
		.pin_in_i(pin_in_i),
		.pin_out_o(pin_out_o),
		.pin_oe_o(pin_oe_o)
	);
	tpo_load_model tpo_load_model_i (.ref_clk_i(ref_clk_i), .pin_out_i(pin_out_o),
		.pin_oe_i(pin_oe_o), .pin_level_o(pin_in_i));
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_write_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_read_i <= 1'b0;
		#1 chk("reg_rdata_o", {8'h00, e}, {8'h00, reg_rdata_o});
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (2000) @(posedge ref_clk_i);
		mismatches++;
		finish_test();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(4'h8, 8'hff);
		rd(4'h9, 8'hf0);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			{compare_a_i, compare_b_i, capture_a_i} <= rows[i].t;
			@(posedge ref_clk_i);
			{compare_a_i, compare_b_i, capture_a_i} <= 9'h000;
			// copy lands on the edge that ends the trigger cycle
			@(posedge ref_clk_i);
			#1 chk("pin_out_o", rows[i].o, pin_out_o);
		end
		chk("pin_oe_o", 16'hff00, pin_oe_o);
		$display("row table done");
		rd(4'h9, 8'hfc);
		rd(4'ha, 8'h00);
		rd(4'hd, 8'h00);
		wr(4'h6, 8'h3c);
		rd(4'h6, 8'h3c);
		$display("readback done");
		wr(4'h7, 8'h59);
		#1 compare_a_i <= 3'h1;
		wr(4'h5, 8'h00);
		compare_a_i <= 3'h0;
		@(posedge ref_clk_i);
		#1 chk("pin_out_o", 16'h59f5, pin_out_o);
		$display("collision done");
		pin_taken_i <= 16'h8000;
		wr(4'h7, 8'h00);
		compare_a_i <= 3'h1;
		@(posedge ref_clk_i);
		compare_a_i <= 3'h0;
		@(posedge ref_clk_i);
		#1 chk("pin_out_o", 16'h00f5, pin_out_o);
		chk("pin_oe_o", 16'h7f00, pin_oe_o);
		$display("taken pin done");
		reset_i <= 1'b1;
		pin_taken_i <= 16'h0000;
		repeat (2) @(posedge ref_clk_i);
		#1 chk("pin_out_o", 16'h0000, pin_out_o);
		chk("pin_oe_o", 16'h0000, pin_oe_o);
		reset_i <= 1'b0;
		rd(4'h8, 8'hff);
		$display("reset done");
		finish_test();
	end
endmodule // tpo_pattern_output_unit_test
